// ### ppl_pkg.sv
// What this block does
// - sequence picks source, 00 none to 11 blue
// - source select held low during reset
// - no source enabled until init finishes
// - notify pin marks init in progress, completion
// - notify pin released while reset applied
// - comparator input decides each conversion step
// - charge pin drives comparator reference side
// - device masters serial clock to flash
// - two active-low selects, spi_cmd.sel high picks the spare
// - receive data sampled from flash output
// - transmit data driven to flash input
// - control port served as two-wire slave
// - control pins only pull low or release
// - charge pin feeds thermistor rc network
// - thermistor power only while measurement enabled
package ppl_pkg;
   // clock and derived timing counts
   localparam int CLK_PERIOD_PS = 5000;
   localparam int INIT_TIME_US = 1000;
   localparam int INIT_CYCLES = INIT_TIME_US * 1000000 / CLK_PERIOD_PS;
   localparam int INIT_CNT_W = 18;
   localparam int DISCH_TIME_NS = 2000;
   localparam int DISCH_CYC = (DISCH_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int CHARGE_STEP_NS = 50;
   localparam int CHARGE_STEP_CYC = (CHARGE_STEP_NS * 1000
      + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SPI_HALF_NS = 25;
   localparam int SPI_HALF_CYC = (SPI_HALF_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   // field widths and codes
   localparam int ADC_BITS = 8;
   localparam int ADC_CNT_W = 16;
   localparam logic [6:0] CTRL_PORT_ADDR = 7'h1B;
   localparam logic [1:0] LIGHT_NONE = 2'h0;
   localparam logic [ADC_BITS-1:0] ADC_MSB = 8'h80;

   typedef enum logic [3:0] {
      AD_IDLE = 4'h1, AD_DISCH = 4'h2, AD_CHARGE = 4'h4, AD_SAMPLE = 4'h8
   } ppl_adc_st_t;
   typedef enum logic [2:0] {
      SP_IDLE = 3'h1, SP_LOW = 3'h2, SP_HIGH = 3'h4
   } ppl_spi_st_t;
   typedef enum logic [5:0] {
      I2_IDLE = 6'h01, I2_ADDR = 6'h02, I2_ACK = 6'h04,
      I2_WDATA = 6'h08, I2_RDATA = 6'h10, I2_RACK = 6'h20
   } ppl_i2c_st_t;

   // serial flash byte request
   typedef struct packed {
      logic start;
      logic sel;
      logic last;
      logic [7:0] data;
   } ppl_spi_cmd_t;

   // whole block state
   typedef struct packed {
      logic init_done;
      logic [INIT_CNT_W-1:0] init_cnt;
      logic notify_oe_n;
      logic [1:0] light_sel;
      ppl_adc_st_t adc_st;
      logic [ADC_BITS-1:0] adc_trial;
      logic [ADC_BITS-1:0] adc_bit;
      logic [ADC_CNT_W-1:0] adc_cnt;
      logic charge;
      logic [ADC_BITS-1:0] adc_result;
      logic adc_done;
      logic therm_pwr;
      logic [1:0] cmp_sync;
      ppl_spi_st_t spi_st;
      logic [7:0] spi_sh;
      logic [3:0] spi_bits;
      logic [7:0] spi_div;
      logic sclk;
      logic cs0_n;
      logic cs1_n;
      logic mosi;
      logic spi_busy;
      logic spi_done;
      logic spi_last;
      logic [7:0] spi_rx;
      logic [1:0] miso_sync;
      ppl_i2c_st_t i2_st;
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      logic [3:0] i2_cnt;
      logic [7:0] i2_sh;
      logic i2_rw;
      logic i2_first;
      logic sda_oe_n;
      logic scl_oe_n;
      logic pin_low;
      logic wr_valid;
      logic wr_first;
      logic [7:0] wr_data;
      logic rd_req;
   } ppl_state_t;

   // reset image of the state
   function automatic ppl_state_t ppl_reset_state();
      ppl_state_t r;
      r = '0;
      r.notify_oe_n = 1'b1;
      r.adc_st = AD_IDLE;
      r.spi_st = SP_IDLE;
      r.i2_st = I2_IDLE;
      r.cs0_n = 1'b1;
      r.cs1_n = 1'b1;
      r.sda_oe_n = 1'b1;
      r.scl_oe_n = 1'b1;
      r.scl_sync = 3'h7;
      r.sda_sync = 3'h7;
      return r;
   endfunction
endpackage

// ### ppl_pins.sv
`timescale 1ns/1ps
module ppl_pins
   import ppl_pkg::*;
#(
   parameter int INIT_CYC = INIT_CYCLES
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // light source
   input wire logic [1:0] seq_light_req,
   output logic [1:0] light_source_select,
   // host notification, open drain
   output logic host_notify_out,
   output logic host_notify_oe_n,
   output logic init_done,
   // thermistor converter
   input wire logic adc_enable,
   input wire logic adc_start,
   input wire logic comparator_result_in,
   output logic ramp_charge_out,
   output logic therm_power_out,
   output logic [ADC_BITS-1:0] adc_result,
   output logic adc_done,
   // serial flash master
   input wire ppl_spi_cmd_t spi_cmd,
   input wire logic flash_serial_in,
   output logic flash_serial_clock,
   output logic flash_select_n,
   output logic spare_select_n,
   output logic flash_serial_out,
   output logic spi_busy,
   output logic spi_done,
   output logic [7:0] spi_rx_data,
   // two-wire control port, open drain
   input wire logic control_port_clock_in,
   output logic control_port_clock_out,
   output logic control_port_clock_oe_n,
   input wire logic control_port_data_in,
   output logic control_port_data_out,
   output logic control_port_data_oe_n,
   // control port user side
   output logic ctrl_wr_valid,
   output logic ctrl_wr_first,
   output logic [7:0] ctrl_wr_data,
   output logic ctrl_rd_req,
   input wire logic [7:0] ctrl_rd_data
);
   ppl_state_t s_reg; // all state
   ppl_state_t s_next; // next state
   logic [ADC_CNT_W-1:0] charge_target; // charge time for trial code
   logic [ADC_BITS-1:0] trial_kept; // trial after compare decision
   logic scl, scl_p, sda, sda_p; // synced pins and previous samples
   logic scl_rise, scl_fall, i2_start, i2_stop; // bus events

   // next state
   always_comb
   begin
      s_next = s_reg;
      // one-cycle pulses default low
      s_next.adc_done = 1'b0;
      s_next.spi_done = 1'b0;
      s_next.wr_valid = 1'b0;
      s_next.rd_req = 1'b0;
      // pin synchronisers, only stage 1 and later are read
      s_next.cmp_sync = {s_reg.cmp_sync[0], comparator_result_in};
      s_next.miso_sync = {s_reg.miso_sync[0], flash_serial_in};
      s_next.scl_sync = {s_reg.scl_sync[1:0], control_port_clock_in};
      s_next.sda_sync = {s_reg.sda_sync[1:0], control_port_data_in};
      scl = s_reg.scl_sync[1];
      scl_p = s_reg.scl_sync[2];
      sda = s_reg.sda_sync[1];
      sda_p = s_reg.sda_sync[2];
      scl_rise = scl & ~scl_p;
      scl_fall = ~scl & scl_p;
      i2_start = scl & scl_p & sda_p & ~sda;
      i2_stop = scl & scl_p & ~sda_p & sda;
      charge_target = ADC_CNT_W'({8'h00, s_reg.adc_trial}
         * 16'(CHARGE_STEP_CYC));
      trial_kept = s_reg.cmp_sync[1] ? s_reg.adc_trial
         : (s_reg.adc_trial & ~s_reg.adc_bit);

      // auto-initialisation timer
      if (!s_reg.init_done)
      begin
         if (s_reg.init_cnt == INIT_CNT_W'(INIT_CYC - 1))
            s_next.init_done = 1'b1;
         else
            s_next.init_cnt = s_reg.init_cnt + 1'b1;
      end
      // pull low while busy, release once done
      s_next.notify_oe_n = s_reg.init_done;
      // source stays off until init has finished
      s_next.light_sel = s_reg.init_done ? seq_light_req
         : LIGHT_NONE;
      // thermistor supply only while measuring is enabled
      s_next.therm_pwr = s_reg.init_done & adc_enable;

      // successive approximation converter
      unique case (s_reg.adc_st)
         AD_IDLE:
         begin
            s_next.charge = 1'b0;
            if (adc_start && s_reg.therm_pwr)
            begin
               s_next.adc_bit = ADC_MSB;
               s_next.adc_trial = ADC_MSB;
               s_next.adc_cnt = '0;
               s_next.adc_st = AD_DISCH;
            end
         end
         AD_DISCH:
         begin
            // rc network drained before each trial
            s_next.charge = 1'b0;
            if (s_reg.adc_cnt == ADC_CNT_W'(DISCH_CYC - 1))
            begin
               s_next.adc_cnt = '0;
               s_next.adc_st = AD_CHARGE;
            end
            else
               s_next.adc_cnt = s_reg.adc_cnt + 1'b1;
         end
         AD_CHARGE:
         begin
            // charge time sets the reference level
            if (s_reg.adc_cnt >= charge_target)
            begin
               s_next.charge = 1'b0;
               s_next.adc_st = AD_SAMPLE;
            end
            else
            begin
               s_next.charge = 1'b1;
               s_next.adc_cnt = s_reg.adc_cnt + 1'b1;
            end
         end
         AD_SAMPLE:
         begin
            // charging stopped on entry to this state; the compare read was taken two cycles earlier
            s_next.adc_cnt = '0;
            if (s_reg.adc_bit[0])
            begin
               s_next.adc_result = trial_kept;
               s_next.adc_done = 1'b1;
               s_next.adc_st = AD_IDLE;
            end
            else
            begin
               s_next.adc_bit = s_reg.adc_bit >> 1;
               s_next.adc_trial = trial_kept | (s_reg.adc_bit >> 1);
               s_next.adc_st = AD_DISCH;
            end
         end
      endcase

      // serial flash master, mode 0, msb first
      unique case (s_reg.spi_st)
         SP_IDLE:
         begin
            if (spi_cmd.start)
            begin
               s_next.cs0_n = spi_cmd.sel;
               s_next.cs1_n = ~spi_cmd.sel;
               s_next.spi_sh = spi_cmd.data;
               s_next.mosi = spi_cmd.data[7];
               s_next.spi_last = spi_cmd.last;
               s_next.spi_bits = '0;
               s_next.spi_div = '0;
               s_next.spi_busy = 1'b1;
               s_next.spi_st = SP_LOW;
            end
         end
         SP_LOW:
         begin
            if (s_reg.spi_div == 8'(SPI_HALF_CYC - 1))
            begin
               s_next.spi_div = '0;
               s_next.sclk = 1'b1;
               s_next.spi_sh = {s_reg.spi_sh[6:0],
                  s_reg.miso_sync[1]};
               s_next.spi_bits = s_reg.spi_bits + 1'b1;
               s_next.spi_st = SP_HIGH;
            end
            else
               s_next.spi_div = s_reg.spi_div + 1'b1;
         end
         SP_HIGH:
         begin
            if (s_reg.spi_div == 8'(SPI_HALF_CYC - 1))
            begin
               s_next.spi_div = '0;
               s_next.sclk = 1'b0;
               if (s_reg.spi_bits == 4'h8)
               begin
                  s_next.spi_rx = s_reg.spi_sh;
                  s_next.spi_done = 1'b1;
                  s_next.spi_busy = 1'b0;
                  s_next.spi_st = SP_IDLE;
                  // select kept low between bytes of one transfer
                  if (s_reg.spi_last)
                  begin
                     s_next.cs0_n = 1'b1;
                     s_next.cs1_n = 1'b1;
                  end
               end
               else
               begin
                  s_next.mosi = s_reg.spi_sh[7];
                  s_next.spi_st = SP_LOW;
               end
            end
            else
               s_next.spi_div = s_reg.spi_div + 1'b1;
         end
      endcase

      // two-wire slave; start and stop override any state
      if (i2_start)
      begin
         s_next.i2_st = I2_ADDR;
         s_next.i2_cnt = '0;
         s_next.i2_first = 1'b1;
         s_next.sda_oe_n = 1'b1;
      end
      else if (i2_stop)
      begin
         s_next.i2_st = I2_IDLE;
         s_next.sda_oe_n = 1'b1;
      end
      else
      begin
         unique case (s_reg.i2_st)
            I2_IDLE:
               s_next.sda_oe_n = 1'b1;
            I2_ADDR:
            begin
               if (scl_rise)
               begin
                  s_next.i2_sh = {s_reg.i2_sh[6:0], sda};
                  s_next.i2_cnt = s_reg.i2_cnt + 1'b1;
               end
               else if (scl_fall && s_reg.i2_cnt == 4'h8)
               begin
                  s_next.i2_cnt = '0;
                  // foreign address: stay off the bus
                  if (s_reg.i2_sh[7:1] == CTRL_PORT_ADDR)
                  begin
                     s_next.i2_rw = s_reg.i2_sh[0];
                     s_next.sda_oe_n = 1'b0;
                     s_next.i2_st = I2_ACK;
                  end
                  else
                     s_next.i2_st = I2_IDLE;
               end
            end
            I2_ACK:
            begin
               if (scl_fall)
               begin
                  s_next.i2_cnt = '0;
                  if (s_reg.i2_rw)
                  begin
                     s_next.i2_sh = ctrl_rd_data;
                     s_next.rd_req = 1'b1;
                     s_next.sda_oe_n = ctrl_rd_data[7];
                     s_next.i2_st = I2_RDATA;
                  end
                  else
                  begin
                     s_next.sda_oe_n = 1'b1;
                     s_next.i2_st = I2_WDATA;
                  end
               end
            end
            I2_WDATA:
            begin
               if (scl_rise)
               begin
                  s_next.i2_sh = {s_reg.i2_sh[6:0], sda};
                  s_next.i2_cnt = s_reg.i2_cnt + 1'b1;
                  if (s_reg.i2_cnt == 4'h7)
                  begin
                     s_next.wr_valid = 1'b1;
                     s_next.wr_first = s_reg.i2_first;
                     s_next.wr_data = {s_reg.i2_sh[6:0], sda};
                     s_next.i2_first = 1'b0;
                  end
               end
               else if (scl_fall && s_reg.i2_cnt == 4'h8)
               begin
                  s_next.sda_oe_n = 1'b0;
                  s_next.i2_st = I2_ACK;
               end
            end
            I2_RDATA:
            begin
               if (scl_rise)
                  s_next.i2_cnt = s_reg.i2_cnt + 1'b1;
               else if (scl_fall)
               begin
                  if (s_reg.i2_cnt == 4'h8)
                  begin
                     s_next.sda_oe_n = 1'b1;
                     s_next.i2_st = I2_RACK;
                  end
                  else
                  begin
                     s_next.i2_sh = {s_reg.i2_sh[6:0], 1'b0};
                     s_next.sda_oe_n = s_reg.i2_sh[6];
                  end
               end
            end
            I2_RACK:
            begin
               // master nack ends the read
               if (scl_rise)
                  s_next.i2_st = sda ? I2_IDLE : I2_ACK;
            end
         endcase
      end
   end

   // state register; reset forces the safe pin image
   always_ff @(posedge core_clk)
   begin
      if (rst)
         s_reg <= ppl_reset_state();
      else
         s_reg <= s_next;
   end

   // outputs straight from the state
   assign light_source_select = s_reg.light_sel;
   assign host_notify_out = s_reg.pin_low;
   assign host_notify_oe_n = s_reg.notify_oe_n;
   assign init_done = s_reg.init_done;
   assign ramp_charge_out = s_reg.charge;
   assign therm_power_out = s_reg.therm_pwr;
   assign adc_result = s_reg.adc_result;
   assign adc_done = s_reg.adc_done;
   assign flash_serial_clock = s_reg.sclk;
   assign flash_select_n = s_reg.cs0_n;
   assign spare_select_n = s_reg.cs1_n;
   assign flash_serial_out = s_reg.mosi;
   assign spi_busy = s_reg.spi_busy;
   assign spi_done = s_reg.spi_done;
   assign spi_rx_data = s_reg.spi_rx;
   // no clock stretching: clock pin never pulled
   assign control_port_clock_out = s_reg.pin_low;
   assign control_port_clock_oe_n = s_reg.scl_oe_n;
   assign control_port_data_out = s_reg.pin_low;
   assign control_port_data_oe_n = s_reg.sda_oe_n;
   assign ctrl_wr_valid = s_reg.wr_valid;
   assign ctrl_wr_first = s_reg.wr_first;
   assign ctrl_wr_data = s_reg.wr_data;
   assign ctrl_rd_req = s_reg.rd_req;
endmodule

// ### ppl_pins_assertions.sv
`timescale 1ns/1ps
module ppl_pins_assertions
   import ppl_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // light and notify
   input wire logic [1:0] seq_light_req,
   input wire logic [1:0] light_source_select,
   input wire logic host_notify_out,
   input wire logic host_notify_oe_n,
   input wire logic init_done,
   // thermistor
   input wire logic adc_enable,
   input wire logic ramp_charge_out,
   input wire logic therm_power_out,
   // serial flash and control port pins
   input wire logic flash_serial_clock,
   input wire logic flash_select_n,
   input wire logic spare_select_n,
   input wire logic flash_serial_out,
   input wire logic control_port_clock_out,
   input wire logic control_port_clock_oe_n,
   input wire logic control_port_data_out
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // length of the low run before each ramp, saturating
   logic [15:0] low_cnt = 16'h0;
   always_ff @(posedge core_clk)
   begin
      if (ramp_charge_out)
         low_cnt <= 16'h0;
      else if (low_cnt != 16'hFFFF)
         low_cnt <= low_cnt + 16'h1;
   end
   sequence ramp_start_s;
      $rose(ramp_charge_out);
   endsequence
   sequence sclk_rise_s;
      $rose(flash_serial_clock);
   endsequence
   chk_reset_image: assert property (
      $fell(rst) |-> light_source_select == LIGHT_NONE && host_notify_oe_n
         && flash_select_n && spare_select_n)
      else $error("outputs wrong right after reset");
   chk_dark_init: assert property (
      !init_done |-> light_source_select == LIGHT_NONE)
      else $error("light source enabled before init done");
   chk_light_follow: assert property (
      $past(init_done) |-> light_source_select == $past(seq_light_req))
      else $error("light select does not follow request");
   chk_notify_busy: assert property (
      !init_done && !$past(rst) |-> !host_notify_oe_n)
      else $error("notify not pulled during init");
   chk_notify_done: assert property (
      init_done && $past(init_done) |-> host_notify_oe_n)
      else $error("notify still pulled after init");
   chk_notify_level: assert property (
      !host_notify_oe_n |-> !host_notify_out)
      else $error("notify driven high");
   chk_therm_power: assert property (
      !$past(rst) |-> therm_power_out == $past(init_done && adc_enable))
      else $error("thermistor power wrong");
   chk_ramp_discharge: assert property (
      ramp_start_s |-> low_cnt >= 16'(DISCH_CYC))
      else $error("ramp started without full discharge");
   chk_mosi_stable: assert property (
      sclk_rise_s |-> $stable(flash_serial_out)
         && (flash_select_n ^ spare_select_n))
      else $error("serial data moved at clock rise");
   chk_sclk_idle: assert property (
      flash_select_n && spare_select_n |-> !flash_serial_clock)
      else $error("serial clock high while deselected");
   chk_one_select: assert property (
      flash_select_n || spare_select_n)
      else $error("both selects low");
   chk_open_drain: assert property (
      !control_port_data_out && !control_port_clock_out
         && control_port_clock_oe_n)
      else $error("control port driven high");
endmodule
bind ppl_pins ppl_pins_assertions u_ppl_pins_assertions (
   .core_clk(core_clk), .rst(rst), .seq_light_req(seq_light_req),
   .light_source_select(light_source_select),
   .host_notify_out(host_notify_out), .host_notify_oe_n(host_notify_oe_n),
   .init_done(init_done), .adc_enable(adc_enable),
   .ramp_charge_out(ramp_charge_out), .therm_power_out(therm_power_out),
   .flash_serial_clock(flash_serial_clock),
   .flash_select_n(flash_select_n), .spare_select_n(spare_select_n),
   .flash_serial_out(flash_serial_out),
   .control_port_clock_out(control_port_clock_out),
   .control_port_clock_oe_n(control_port_clock_oe_n),
   .control_port_data_out(control_port_data_out));

// ### ppl_far_model.sv
`timescale 1ns/1ps
module ppl_far_model
   import ppl_pkg::*;
(
   // clock
   input wire logic core_clk,
   // flash pins
   input wire logic flash_serial_clock,
   input wire logic flash_select_n,
   input wire logic flash_serial_out,
   output logic flash_serial_in,
   input wire logic [7:0] flash_byte,
   output logic [7:0] got_byte,
   // comparator side
   input wire logic ramp_charge_out,
   input wire logic [7:0] therm_level,
   output logic comparator_result_in
);
   logic sclk_q = 1'b0;
   logic cs_q = 1'b1;
   logic [7:0] sh = 8'h0;
   logic [15:0] ramp = 16'h0;
   logic [15:0] low = 16'h0;
   initial flash_serial_in = 1'b0;
   // high while the ramp is below the thermistor; half-step margin
   assign comparator_result_in =
      ramp < 16'(therm_level) * 16'hA + 16'h5;
   // rc node: grows while charged, bleeds off only after a long low
   always @(posedge core_clk)
   begin
      if (ramp_charge_out)
      begin
         ramp <= ramp + 16'h1;
         low <= 16'h0;
      end
      else
      begin
         low <= low + 16'h1;
         if (low > 16'h14)
            ramp <= 16'h0;
      end
   end
   // flash, mode 0: next bit after each falling clock
   always @(posedge core_clk)
   begin
      sclk_q <= flash_serial_clock;
      cs_q <= flash_select_n;
      if (flash_select_n)
         flash_serial_in <= ~flash_serial_in; // released, no stale bit
      else if (cs_q)
      begin
         flash_serial_in <= flash_byte[7];
         sh <= {flash_byte[6:0], 1'b0};
      end
      else if (sclk_q && !flash_serial_clock)
      begin
         flash_serial_in <= sh[7];
         sh <= {sh[6:0], 1'b0};
      end
      if (!flash_select_n && !sclk_q && flash_serial_clock)
         got_byte <= {got_byte[6:0], flash_serial_out};
   end
endmodule

// ### tb_ppl_pins.sv
`timescale 1ns/1ps
module tb_ppl_pins
   import ppl_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] seq_light_req = 2'h3;
   logic adc_enable = 1'b1;
   logic adc_start = 1'b0;
   ppl_spi_cmd_t spi_cmd = '0;
   logic scl_m = 1'b1;
   logic sda_m = 1'b1;
   logic [7:0] ctrl_rd_data = 8'h0;
   logic [7:0] therm_level = 8'h0;
   logic [7:0] flash_byte = 8'h0;
   logic [7:0] got_byte, wr_seen, v, adc_result, spi_rx_data, ctrl_wr_data;
   logic [1:0] light_source_select;
   logic host_notify_out, host_notify_oe_n, init_done, ramp_charge_out;
   logic adc_done, cmp_w, miso_w, flash_serial_clock, flash_select_n, busy;
   logic spare_select_n, flash_serial_out, spi_done, ack, ctrl_wr_valid;
   logic scl_o, scl_oe_n, sda_o, sda_oe_n, scl_w, sda_w;
   logic [31:0] lfsr = 32'h675c;
   int fails = 0;
   int total_checks = 0;
   // open-drain wires: master release and design pull-down
   assign scl_w = scl_m & (scl_oe_n | scl_o);
   assign sda_w = sda_m & (sda_oe_n | sda_o);
   always #2.5 core_clk = ~core_clk;
   // last byte written through the control port
   always @(posedge core_clk)
      if (ctrl_wr_valid === 1'b1)
         wr_seen <= ctrl_wr_data;
   ppl_pins #(.INIT_CYC(20)) u_ppl_pins (.core_clk(core_clk), .rst(rst),
      .seq_light_req(seq_light_req), .light_source_select(light_source_select),
      .host_notify_out(host_notify_out), .host_notify_oe_n(host_notify_oe_n),
      .init_done(init_done), .adc_enable(adc_enable), .adc_start(adc_start),
      .comparator_result_in(cmp_w), .ramp_charge_out(ramp_charge_out),
      .therm_power_out(), .adc_result(adc_result), .adc_done(adc_done),
      .spi_cmd(spi_cmd), .flash_serial_in(miso_w),
      .flash_serial_clock(flash_serial_clock), .flash_select_n(flash_select_n),
      .spare_select_n(spare_select_n), .flash_serial_out(flash_serial_out),
      .spi_busy(busy), .spi_done(spi_done), .spi_rx_data(spi_rx_data),
      .control_port_clock_in(scl_w), .control_port_clock_out(scl_o),
      .control_port_clock_oe_n(scl_oe_n), .control_port_data_in(sda_w),
      .control_port_data_out(sda_o), .control_port_data_oe_n(sda_oe_n),
      .ctrl_wr_valid(ctrl_wr_valid), .ctrl_wr_first(),
      .ctrl_wr_data(ctrl_wr_data), .ctrl_rd_req(), .ctrl_rd_data(ctrl_rd_data));
   ppl_far_model u_ppl_far_model (.core_clk(core_clk),
      .flash_serial_clock(flash_serial_clock), .flash_select_n(flash_select_n),
      .flash_serial_out(flash_serial_out), .flash_serial_in(miso_w),
      .flash_byte(flash_byte), .got_byte(got_byte),
      .ramp_charge_out(ramp_charge_out), .therm_level(therm_level),
      .comparator_result_in(cmp_w));
   // next random value, shift-register style
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // bounded wait: 0 init done, 1 conversion done, 2 byte done
   task wait_on(input int sel, input int lim);
      for (int k = 0; k < lim; k++)
      begin
         @(posedge core_clk);
         #1;
         if (sel == 0 ? init_done === 1'b1 : sel == 1 ? adc_done === 1'b1
               : spi_done === 1'b1)
            return;
      end
      fails++;
      $display("Error at %0t: wait %h ran out", $time, sel);
      close_out();
   endtask
   // one scl period; slow enough for the input synchronisers
   task i2c_bit(input logic b, output logic r);
      sda_m <= b;
      cyc(8);
      scl_m <= 1'b1;
      cyc(8);
      r = sda_w;
      scl_m <= 1'b0;
      cyc(8);
   endtask
   task i2c_byte(input logic [7:0] d, output logic a);
      logic r;
      for (int i = 7; i >= 0; i--)
         i2c_bit(d[i], r);
      i2c_bit(1'b1, a);
   endtask
   task i2c_edge(input logic s0, input logic c1, input logic s2);
      sda_m <= s0;
      cyc(8);
      scl_m <= c1;
      cyc(8);
      sda_m <= s2;
      cyc(8);
   endtask
   initial
   begin
      cyc(3);
      #1;
      chk(light_source_select, 2'h0);
      chk(host_notify_oe_n, 1'b1);
      chk({flash_select_n, spare_select_n}, 2'h3);
      @(posedge core_clk) rst <= 1'b0;
      cyc(3);
      #1;
      chk(light_source_select, 2'h0);
      chk(host_notify_oe_n, 1'b0);
      wait_on(0, 100);
      cyc(2);
      #1;
      chk(host_notify_oe_n, 1'b1);
      // every code, then random requests
      for (int i = 0; i < 10; i++)
      begin
         lfsr = nxt(lfsr);
         @(posedge core_clk) seq_light_req <= i < 4 ? 2'(i) : lfsr[1:0];
         @(posedge core_clk);
         #1;
         chk(light_source_select, seq_light_req);
      end
      // conversions: both ends of the range, then random
      for (int i = 0; i < 4; i++)
      begin
         lfsr = nxt(lfsr);
         v = i == 0 ? 8'h0 : i == 1 ? 8'hFF : lfsr[7:0];
         @(posedge core_clk) therm_level <= v;
         adc_start <= 1'b1;
         @(posedge core_clk) adc_start <= 1'b0;
         wait_on(1, 25000);
         chk(adc_result, v);
      end
      // flash bytes, each a whole transfer
      for (int i = 0; i < 4; i++)
      begin
         lfsr = nxt(lfsr);
         v = i == 0 ? 8'h0 : i == 1 ? 8'hFF : lfsr[7:0];
         @(posedge core_clk) flash_byte <= lfsr[15:8];
         spi_cmd <= {1'b1, 1'b0, 1'b1, v};
         @(posedge core_clk) spi_cmd.start <= 1'b0;
         #1;
         chk(busy, 1'b1);
         wait_on(2, 200);
         chk(busy, 1'b0);
         chk(spi_rx_data, flash_byte);
         chk(got_byte, v);
         cyc(1);
         #1;
         chk(flash_select_n, 1'b1);
      end
      // control port: own address acked, write delivered
      @(posedge core_clk) ctrl_rd_data <= lfsr[23:16];
      i2c_edge(1'b1, 1'b1, 1'b0);
      scl_m <= 1'b0;
      cyc(8);
      i2c_byte({CTRL_PORT_ADDR, 1'b0}, ack);
      chk(ack, 1'b0);
      i2c_byte(lfsr[31:24], ack);
      chk(ack, 1'b0);
      chk(wr_seen, lfsr[31:24]);
      i2c_edge(1'b0, 1'b1, 1'b1);
      // other address left alone
      i2c_edge(1'b1, 1'b1, 1'b0);
      scl_m <= 1'b0;
      cyc(8);
      i2c_byte({CTRL_PORT_ADDR ^ 7'h01, 1'b0}, ack);
      chk(ack, 1'b1);
      i2c_edge(1'b0, 1'b1, 1'b1);
      // read one byte back, master nack ends it
      i2c_edge(1'b1, 1'b1, 1'b0);
      scl_m <= 1'b0;
      cyc(8);
      i2c_byte({CTRL_PORT_ADDR, 1'b1}, ack);
      chk(ack, 1'b0);
      for (int i = 7; i >= 0; i--)
         i2c_bit(1'b1, v[i]);
      i2c_bit(1'b1, ack);
      chk(v, ctrl_rd_data);
      i2c_edge(1'b0, 1'b1, 1'b1);
      // reset in mid-run, then init again
      rst <= 1'b1;
      seq_light_req <= 2'h2;
      cyc(3);
      #1;
      chk(light_source_select, 2'h0);
      chk(host_notify_oe_n, 1'b1);
      @(posedge core_clk) rst <= 1'b0;
      wait_on(0, 100);
      cyc(2);
      #1;
      chk(light_source_select, 2'h2);
      close_out();
   end
endmodule
